// ==== shared/modem_irq_pkg.sv ====
// package: register map, field positions, reset values, carried structs
// assumes: APB slave, 32-bit data, word-aligned registers
package modem_irq_pkg;
	localparam int NUM_CHAN = 4;
	localparam logic [7:0] OFF_MODEM_CTL  = 8'h00;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h04;
	localparam logic [7:0] OFF_COND_SET   = 8'h08;
	localparam logic [7:0] OFF_COND_STAT  = 8'h0C;
	localparam logic [7:0] OFF_EVT_STAT   = 8'h10;
	localparam logic [7:0] OFF_EVT_MASK   = 8'h14;
	localparam logic [7:0] OFF_MODE       = 8'h18;
	localparam logic [7:0] OFF_PIN_STAT   = 8'h1C;
	localparam int TERM_READY_BIT = 0;
	localparam int IRQ_OE_BIT     = 3;
	localparam int SRC_RX_DATA = 0;
	localparam int SRC_TX_EMPTY = 1;
	localparam int SRC_RX_ERROR = 2;
	localparam int SRC_MODEM    = 3;
	localparam logic [7:0] MODEM_CTL_RESET  = 8'h00;
	localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
	localparam logic       MODE_RESET       = 1'b0;
	typedef enum logic [0:0] {
		BUS_MODE_16 = 1'b0,
		BUS_MODE_68 = 1'b1
	} bus_mode_t;
	typedef enum logic [1:0] {
		APB_IDLE   = 2'b00,
		APB_ACCESS = 2'b01
	} apb_state_t;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic rxError;
		logic rxData;
		logic txEmpty;
		logic modemChange;
	} irq_cond_t;
endpackage : modem_irq_pkg

// ==== core/chan_irq_gate.sv ====
// holds: one channel's interrupt gating
// assumes: enables are already registered by the caller; conditions come straight from its input ports
`timescale 1ns/1ns
module chan_irq_gate
(
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire modem_irq_pkg::irq_cond_t cond,
	input  wire logic [3:0]               enable,
	input  wire logic                     outEnable,
	input  wire logic                     mode16,
	output logic                          irq
);
	logic irq_d;
	logic irq_q;
	logic [3:0] condVec;
	always_comb
	begin
		condVec = 4'h0;
		condVec[modem_irq_pkg::SRC_RX_DATA]  = cond.rxData;
		condVec[modem_irq_pkg::SRC_TX_EMPTY] = cond.txEmpty;
		condVec[modem_irq_pkg::SRC_RX_ERROR] = cond.rxError;
		condVec[modem_irq_pkg::SRC_MODEM]    = cond.modemChange;
		// drops in the cycle after the last enabled condition clears
		irq_d = outEnable && mode16 && |(condVec & enable);
	end
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d;
	end
	assign irq = irq_q;
endmodule : chan_irq_gate

// ==== core/modem_ready_irq.sv ====
// holds: terminal-ready outputs, ready-input status, per-channel interrupts, APB slave
// assumes: one clock, synchronous active-low reset, pins synchronous to clk
//
// Summary of operation
// - ready input never touches serial transmit or receive.
// - writing one to control bit 0 drives terminal-ready low.
// - writing zero, or reset, drives terminal-ready high.
// - terminal-ready level has no effect on serial behaviour.
// - one active-high interrupt output per channel.
// - channel interrupts presented only in the 16-style bus mode.
// - interrupt needs output-enable bit, enabled source, and pending condition.
// - rx error, rx data, tx empty, modem change are conditions.
// - 68-style mode reassigns interrupt pins; they are not driven.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module modem_ready_irq
#(
	parameter int CHANNELS = modem_irq_pkg::NUM_CHAN
)
(
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [CHANNELS-1:0]   dataSetReady_b,
	input  wire logic [CHANNELS-1:0]   rxErrorCond,
	input  wire logic [CHANNELS-1:0]   rxDataCond,
	input  wire logic [CHANNELS-1:0]   txEmptyCond,
	input  wire logic [CHANNELS-1:0]   modemChangeCond,
	output logic [CHANNELS-1:0]        terminalReady_b,
	output logic [CHANNELS-1:0]        chanIrq,
	output logic [CHANNELS-1:0]        chanIrqOe,
	output logic                       evtIrq
);
	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	modem_irq_pkg::apb_req_t   req;
	modem_irq_pkg::apb_state_t state_q;
	modem_irq_pkg::apb_state_t state_d;
	logic [7:0]              modemCtl_q   [CHANNELS];
	logic [7:0]              modemCtl_d   [CHANNELS];
	logic [3:0]              irqEnable_q  [CHANNELS];
	logic [3:0]              irqEnable_d  [CHANNELS];
	modem_irq_pkg::bus_mode_t mode_q;
	modem_irq_pkg::bus_mode_t mode_d;
	logic [CHANNELS-1:0]     termReady_q;
	logic [CHANNELS-1:0]     termReady_d;
	logic [CHANNELS-1:0]     dsrPrev_q;
	logic [CHANNELS-1:0]     evtStat_q;
	logic [CHANNELS-1:0]     evtStat_d;
	logic [CHANNELS-1:0]     evtMask_q;
	logic [CHANNELS-1:0]     evtMask_d;
	logic [CHANNELS-1:0]     oe_q;
	logic [CHANNELS-1:0]     oe_d;
	logic                    evtIrq_q;
	logic                    evtIrq_d;
	logic [31:0]             prdata_q;
	logic [31:0]             prdata_d;
	logic                    pready_q;
	logic                    pready_d;
	logic                    pslverr_q;
	logic                    pslverr_d;
	logic [CHANNELS-1:0]     gatedIrq;
	logic [CHANNELS-1:0]     dsrEdge;
	logic                    acc;
	logic                    wr;
	logic                    rd;
	logic [1:0]              chanSel;
	logic [7:0]              regOff;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
	// upper address bits pick the channel; lower pick the register
	assign chanSel = req.paddr[6:5];
	assign regOff  = {3'b000, req.paddr[4:0]};
	// one wait state: answer lands on the second access cycle
	assign acc = req.psel && req.penable && (state_q == modem_irq_pkg::APB_ACCESS) && !pready_q;
	assign wr  = acc && req.pwrite;
	assign rd  = acc && !req.pwrite;
	// ready input only feeds status and the event bit, never serial logic
	assign dsrEdge = dataSetReady_b ^ dsrPrev_q;

	// ------------------------------------------------------------
	// per-channel interrupt gates
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : gen_chan
			modem_irq_pkg::irq_cond_t cnd;
			assign cnd = '{rxError: rxErrorCond[g], rxData: rxDataCond[g],
				txEmpty: txEmptyCond[g], modemChange: modemChangeCond[g]};
			chan_irq_gate u_gate
			(
				.clk       (clk),
				.rst_b     (rst_b),
				.cond      (cnd),
				.enable    (irqEnable_q[g]),
				.outEnable (modemCtl_q[g][modem_irq_pkg::IRQ_OE_BIT]),
				.mode16    (mode_q == modem_irq_pkg::BUS_MODE_16),
				.irq       (gatedIrq[g])
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------
	always_comb
	begin
		state_d   = state_q;
		mode_d    = mode_q;
		evtMask_d = evtMask_q;
		prdata_d  = prdata_q;
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		for (int i = 0; i < CHANNELS; i++)
		begin
			modemCtl_d[i]  = modemCtl_q[i];
			irqEnable_d[i] = irqEnable_q[i];
		end
		case (state_q)
			modem_irq_pkg::APB_IDLE:
				if (req.psel && !req.penable)
					state_d = modem_irq_pkg::APB_ACCESS;
			modem_irq_pkg::APB_ACCESS:
				if (pready_q)
					state_d = modem_irq_pkg::APB_IDLE;
			default:
				state_d = modem_irq_pkg::APB_IDLE;
		endcase
		if (acc)
		begin
			pready_d = 1'b1;
			prdata_d = 32'h0000_0000;
		end
		if (wr)
		begin
			if (regOff == modem_irq_pkg::OFF_MODEM_CTL)
				modemCtl_d[chanSel] = req.pwdata[7:0];
			else if (regOff == modem_irq_pkg::OFF_IRQ_ENABLE)
				irqEnable_d[chanSel] = req.pwdata[3:0];
			else if (regOff == modem_irq_pkg::OFF_EVT_MASK)
				evtMask_d = req.pwdata[CHANNELS-1:0];
			else if (regOff == modem_irq_pkg::OFF_MODE)
				mode_d = modem_irq_pkg::bus_mode_t'(req.pwdata[0]);
			else if (regOff == modem_irq_pkg::OFF_PIN_STAT || regOff == modem_irq_pkg::OFF_EVT_STAT
				|| regOff == modem_irq_pkg::OFF_COND_STAT || regOff == modem_irq_pkg::OFF_COND_SET)
				pslverr_d = 1'b0;
			else
				pslverr_d = 1'b1;
		end
		if (rd)
		begin
			if (regOff == modem_irq_pkg::OFF_MODEM_CTL)
				prdata_d = {24'h00_0000, modemCtl_q[chanSel]};
			else if (regOff == modem_irq_pkg::OFF_IRQ_ENABLE)
				prdata_d = {28'h000_0000, irqEnable_q[chanSel]};
			else if (regOff == modem_irq_pkg::OFF_COND_STAT || regOff == modem_irq_pkg::OFF_COND_SET)
				prdata_d = {28'h000_0000, rxErrorCond[chanSel], modemChangeCond[chanSel],
					txEmptyCond[chanSel], rxDataCond[chanSel]};
			else if (regOff == modem_irq_pkg::OFF_EVT_STAT)
				prdata_d = {28'h000_0000, evtStat_q};
			else if (regOff == modem_irq_pkg::OFF_EVT_MASK)
				prdata_d = {28'h000_0000, evtMask_q};
			else if (regOff == modem_irq_pkg::OFF_MODE)
				prdata_d = {31'h0000_0000, mode_q};
			else if (regOff == modem_irq_pkg::OFF_PIN_STAT)
				prdata_d = {24'h00_0000, chanIrq, dataSetReady_b};
			else
				pslverr_d = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// pin outputs and event status
	// ------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < CHANNELS; i++)
			termReady_d[i] = !modemCtl_d[i][modem_irq_pkg::TERM_READY_BIT];
		// in 68 mode the pins carry other functions: release them
		// follows the registered mode so the pin enable moves in step with the gated irq
		oe_d = (mode_q == modem_irq_pkg::BUS_MODE_16) ? {CHANNELS{1'b1}} : {CHANNELS{1'b0}};
		evtStat_d = evtStat_q;
		// read clears; a fresh edge in the same cycle wins
		if (rd && regOff == modem_irq_pkg::OFF_EVT_STAT)
			evtStat_d = {CHANNELS{1'b0}};
		evtStat_d = evtStat_d | dsrEdge;
		evtIrq_d  = |(evtStat_d & evtMask_d);
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			state_q     <= modem_irq_pkg::APB_IDLE;
			mode_q      <= modem_irq_pkg::bus_mode_t'(modem_irq_pkg::MODE_RESET);
			evtMask_q   <= {CHANNELS{1'b0}};
			evtStat_q   <= {CHANNELS{1'b0}};
			evtIrq_q    <= 1'b0;
			dsrPrev_q   <= {CHANNELS{1'b1}};
			termReady_q <= {CHANNELS{1'b1}};
			oe_q        <= {CHANNELS{1'b1}};
			prdata_q    <= 32'h0000_0000;
			pready_q    <= 1'b0;
			pslverr_q   <= 1'b0;
			for (int i = 0; i < CHANNELS; i++)
			begin
				modemCtl_q[i]  <= modem_irq_pkg::MODEM_CTL_RESET;
				irqEnable_q[i] <= modem_irq_pkg::IRQ_ENABLE_RESET;
			end
		end
		else
		begin
			state_q     <= state_d;
			mode_q      <= mode_d;
			evtMask_q   <= evtMask_d;
			evtStat_q   <= evtStat_d;
			evtIrq_q    <= evtIrq_d;
			dsrPrev_q   <= dataSetReady_b;
			termReady_q <= termReady_d;
			oe_q        <= oe_d;
			prdata_q    <= prdata_d;
			pready_q    <= pready_d;
			pslverr_q   <= pslverr_d;
			for (int i = 0; i < CHANNELS; i++)
			begin
				modemCtl_q[i]  <= modemCtl_d[i];
				irqEnable_q[i] <= irqEnable_d[i];
			end
		end
	end

	assign terminalReady_b = termReady_q;
	assign chanIrq         = gatedIrq;
	assign chanIrqOe       = oe_q;
	assign evtIrq          = evtIrq_q;
	assign prdata          = prdata_q;
	assign pready          = pready_q;
	assign pslverr         = pslverr_q;
endmodule : modem_ready_irq

// ==== test/modem_ready_irq_properties.sv ====
// checker: port-level timing of terminal-ready, channel irq and apb answer
// assumes: bound into modem_ready_irq, single clock, sync active-low reset
`timescale 1ns/1ns
module modem_ready_irq_properties
#(
	parameter int CHANNELS = 4
)
(
	input wire logic                clk,
	input wire logic                rst_b,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         pwdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic [CHANNELS-1:0] rxErrorCond,
	input wire logic [CHANNELS-1:0] rxDataCond,
	input wire logic [CHANNELS-1:0] txEmptyCond,
	input wire logic [CHANNELS-1:0] modemChangeCond,
	input wire logic [CHANNELS-1:0] terminalReady_b,
	input wire logic [CHANNELS-1:0] chanIrq,
	input wire logic [CHANNELS-1:0] chanIrqOe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ----------------
	// helpers
	// ----------------
	wire logic                ctlWr = psel && penable && pready && pwrite && paddr == 8'h00;
	wire logic [CHANNELS-1:0] pend  = rxErrorCond | rxDataCond | txEmptyCond | modemChangeCond;
	// ----------------
	// properties
	// ----------------
	reset_idle_a: assert property (@(posedge clk) disable iff (1'b0) !rst_b |=> terminalReady_b == '1 && chanIrq == '0)
		else $error("outputs not idle after reset");
	irq_oe_gate_a: assert property ((chanIrq & ~chanIrqOe) == '0)
		else $error("irq driven with pin disabled");
	irq_cause_a: assert property ((chanIrq & ~$past(pend)) == '0)
		else $error("irq without pending condition");
	irq_drop_a: assert property (pend == '0 |=> chanIrq == '0)
		else $error("irq stayed high without condition");
	ready_low_a: assert property (ctlWr && pwdata[0] |-> ##[1:2] !terminalReady_b[0])
		else $error("terminal ready not asserted");
	ready_high_a: assert property (ctlWr && !pwdata[0] |-> ##[1:2] terminalReady_b[0])
		else $error("terminal ready not released");
	apb_answer_a: assert property (psel && !penable |-> ##2 pready)
		else $error("apb answer late");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	err_timing_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	cover property (chanIrq != '0);
	cover property (!chanIrqOe[0]);
	cover property (pslverr);
endmodule : modem_ready_irq_properties

bind modem_ready_irq modem_ready_irq_properties #(.CHANNELS(CHANNELS)) chk (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.rxErrorCond(rxErrorCond), .rxDataCond(rxDataCond), .txEmptyCond(txEmptyCond),
	.modemChangeCond(modemChangeCond), .terminalReady_b(terminalReady_b), .chanIrq(chanIrq), .chanIrqOe(chanIrqOe));

// ==== test/modem_model.sv ====
// holds: modem side of the ready pins
// assumes: modem ready pins synchronous to clk
`timescale 1ns/1ns
module modem_model
(
	input  wire logic       clk,
	input  wire logic [3:0] powered,
	input  wire logic [3:0] terminalReady_b,
	output logic      [3:0] dataSetReady_b
);
	// registered so a change never lands in the bench's own time step
	always_ff @(posedge clk)
	begin
		dataSetReady_b <= ~powered;
	end
endmodule : modem_model

// ==== test/tb_top.sv ====
// testbench: apb call sequences against terminal-ready, irq and event paths
// assumes: modem_ready_irq with four channels, modem_model at the pins
`timescale 1ns/1ns
module tb_top;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, e1, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  powered, dsr_b, src, trdy_b, chanIrq, chanIrqOe, m;
	logic        evtIrq;
	int          n_mismatch, compares, n;
	// conditions only on channel 2; bit order follows the enable layout
	wire logic [3:0] rxDataCond = {1'b0, src[0], 2'b00};
	wire logic [3:0] txEmptyCond = {1'b0, src[1], 2'b00};
	wire logic [3:0] rxErrorCond = {1'b0, src[2], 2'b00};
	wire logic [3:0] modemChangeCond = {1'b0, src[3], 2'b00};
	modem_ready_irq DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dataSetReady_b(dsr_b), .rxErrorCond(rxErrorCond), .rxDataCond(rxDataCond), .txEmptyCond(txEmptyCond),
		.modemChangeCond(modemChangeCond), .terminalReady_b(trdy_b), .chanIrq(chanIrq),
		.chanIrqOe(chanIrqOe), .evtIrq(evtIrq));
	modem_model modem (.clk(clk), .powered(powered), .terminalReady_b(trdy_b), .dataSetReady_b(dsr_b));
	always #10 clk = ~clk;
	// ----------------
	// tasks
	// ----------------
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1);
		rd = prdata; er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask : apb
	task settle;
		repeat (3) @(posedge clk);
		#1;
	endtask : settle
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task finish_test;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// ----------------
	// sequence
	// ----------------
	initial
	begin
		clk = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		powered = 4'h0; src = 4'h0; n_mismatch = 0; compares = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk(32'(trdy_b), 32'h0000_000F);
		chk(32'(chanIrqOe), 32'h0000_000F);
		apb(1, 8'h20, 32'h0000_0001); settle; chk(32'(trdy_b), 32'h0000_000D);
		apb(0, 8'h20, 32'h0000_0000); chk(rd, 32'h0000_0001);
		apb(1, 8'h20, 32'h0000_0000); settle; chk(32'(trdy_b), 32'h0000_000F);
		apb(1, 8'h00, 32'h0000_0001); settle; chk(32'(trdy_b), 32'h0000_000E);
		apb(1, 8'h00, 32'h0000_0000); settle; chk(32'(trdy_b), 32'h0000_000F);
		apb(1, 8'h40, 32'h0000_0008);
		for (int s = 0; s < 4; s++)
		begin
			m = 4'(1 << s);
			src <= m;
			apb(1, 8'h44, 32'(~m)); settle; chk(32'(chanIrq), 32'h0000_0000);
			apb(1, 8'h44, 32'(m)); settle; chk(32'(chanIrq), 32'h0000_0004);
		end
		apb(1, 8'h40, 32'h0000_0000); settle; chk(32'(chanIrq), 32'h0000_0000);
		apb(1, 8'h40, 32'h0000_0008); apb(1, 8'h58, 32'h0000_0001);
		settle; chk(32'({chanIrqOe, chanIrq}), 32'h0000_0000);
		apb(1, 8'h18, 32'h0000_0000); settle; chk(32'(chanIrq), 32'h0000_0004);
		src <= 4'h0; settle; chk(32'(chanIrq), 32'h0000_0000);
		powered <= 4'h1; settle;
		apb(0, 8'h1C, 32'h0000_0000); chk(32'(rd[3:0]), 32'h0000_000E);
		apb(1, 8'h14, 32'h0000_000F); settle; e1 = evtIrq;
		apb(1, 8'h14, 32'h0000_0000); settle; chk(32'(e1 ^ evtIrq), 32'h0000_0001);
		apb(0, 8'h10, 32'h0000_0000); chk(rd, 32'h0000_0001);
		apb(0, 8'h10, 32'h0000_0000); chk(rd, 32'h0000_0000);
		settle; chk(32'(evtIrq), 32'h0000_0000);
		// unaligned offset decodes to no register
		apb(0, 8'h02, 32'h0000_0000); chk(32'(er), 32'h0000_0001);
		finish_test;
	end
	initial
	begin
		#50000;
		n_mismatch++;
		finish_test;
	end
endmodule : tb_top
